// file: shared/chain_defs.svh
`ifndef CHAIN_DEFS_SVH
`define CHAIN_DEFS_SVH

// pins that feed the chain besides the two mode selector pins
`define CHAIN_OTHER_PINS     88
// the two selector pins, which join the chain once the mode is active
`define CHAIN_SELECTOR_PINS  2
// selector level that asks for the chain mode at the host reset release
`define CHAIN_SELECT_LEVEL   1'b0
// reset values of the state
`define HOST_PREV_RST        1'b1
`define RESULT_RST           1'b0
`define RESULT_OE_RST        1'b0
`define LAD_OUT_RST          1'b0
`define LAD_OE_RST           1'b0

`endif

// file: shared/chain_pkg.sv
package chain_pkg;

  // pin ownership: normal functions or the board parity chain
  typedef enum logic {
    MODE_NORMAL,
    MODE_CHAIN
  } test_mode_t;

endpackage

// file: shared/chain_if.sv
`timescale 1ns/10ps
// carries the chain taps to the reducer and its result back
interface chain_if #(
  parameter int W = 90
) ();
  logic [W-1:0] taps;
  logic         result;

  modport drive  (output taps, input result);
  modport reduce (input taps, output result);
endinterface

// file: core/chain_xnor.sv
`timescale 1ns/10ps
// xnor chain over all taps; seeded so that all-low taps give a low result
module chain_xnor (
  chain_if.reduce ch
);
  import chain_pkg::*;

  localparam int W = $bits(ch.taps);

  // refuse a chain too short to mean anything
  if (W < 2) begin : g_chk
    $error("chain_xnor needs at least two taps");
  end

  // each stage xnors the running value with one tap; flipping any tap flips the end
  function automatic logic xnor_chain(input logic [W-1:0] v);
    logic r;
    r = (W % 2 == 1) ? 1'b1 : 1'b0;
    for (int i = 0; i < W; i++) begin
      r = ~(r ^ v[i]);
    end
    return r;
  endfunction

  // purely combinational, no state held here
  always_comb begin
    ch.result = xnor_chain(ch.taps);
  end
endmodule

// file: core/board_parity_test_chain.sv
// How it works
// - both selector pins low at host reset release enters chain mode
// - either selector pin high at host reset release leaves chain mode
// - in chain mode all normal drivers release; only result pin drives
// - flipping any single chain input flips the chain result
// - chain covers every pin but supplies, result pin and host reset
// - result goes on the shared general bit / tachometer pin in chain mode
// - once in chain mode, selector pins are plain chain inputs
// - main supply power-on reset forces the normal mode
// - outside chain mode input toggles never reach the result pin
// - entering with all inputs low gives low; one high gives high
`timescale 1ns/10ps
`include "chain_defs.svh"
module board_parity_test_chain #(
  parameter int P = `CHAIN_OTHER_PINS
) (
  input  wire logic                clk_i,
  input  wire logic                rstn_i,
  input  wire logic                host_reset_n_i,
  input  wire logic                lframe_n_i,
  input  wire logic                lad0_i,
  input  wire logic [P-1:0]        pin_in_i,
  input  wire logic [P-1:0]        func_out_i,
  input  wire logic [P-1:0]        func_oe_i,
  input  wire logic                lad0_func_out_i,
  input  wire logic                lad0_func_oe_i,
  input  wire logic                gp_out_i,
  input  wire logic                gp_oe_i,
  output logic [P-1:0]             pin_out_o,
  output logic [P-1:0]             pin_oe_o,
  output logic                     lad0_out_o,
  output logic                     lad0_oe_o,
  output logic                     chain_result_pin_o,
  output logic                     chain_result_pin_oe_o,
  output chain_pkg::test_mode_t    mode_o
);
  import chain_pkg::*;

  localparam int TAPS = P + `CHAIN_SELECTOR_PINS;

  // refuse a pin count the chain cannot serve
  if (P < 1) begin : g_chk
    $error("board_parity_test_chain needs at least one chain pin");
  end

  typedef struct packed {
    logic         host_prev;
    test_mode_t   mode;
    logic         result;
    logic         result_oe;
    logic [P-1:0] pin_out;
    logic [P-1:0] pin_oe;
    logic         lad_out;
    logic         lad_oe;
  } state_t;

  state_t s_q;
  state_t s_d;
  logic   host_rise;
  logic   select_chain;
  logic   chain_val;

  chain_if #(.W(TAPS)) chain ();

  // every pin except supplies, host reset and the result pin feeds the chain
  assign chain.taps = {pin_in_i, lad0_i, lframe_n_i};
  assign chain_val  = chain.result;

  chain_xnor u_chain (
    .ch (chain.reduce)
  );

  // release of the host reset, seen as a low-to-high step
  assign host_rise    = host_reset_n_i & ~s_q.host_prev;
  assign select_chain = (lframe_n_i == `CHAIN_SELECT_LEVEL)
                      && (lad0_i == `CHAIN_SELECT_LEVEL);

  // next state: mode decision, pin ownership and the result pin
  always_comb begin
    s_d           = s_q;
    s_d.host_prev = host_reset_n_i;
    // the mode only moves at the host reset release
    if (host_rise) begin
      if (select_chain) begin
        s_d.mode = MODE_CHAIN;
      end else begin
        s_d.mode = MODE_NORMAL;
      end
    end
    case (s_d.mode)
      MODE_CHAIN: begin
        // every normal driver lets go; pins only listen
        s_d.pin_out   = '0;
        s_d.pin_oe    = '0;
        s_d.lad_out   = 1'b0;
        s_d.lad_oe    = 1'b0;
        s_d.result    = chain_val;
        s_d.result_oe = 1'b1;
      end
      MODE_NORMAL: begin
        // normal functions own the pins; the chain is cut off
        s_d.pin_out   = func_out_i;
        s_d.pin_oe    = func_oe_i;
        s_d.lad_out   = lad0_func_out_i;
        s_d.lad_oe    = lad0_func_oe_i;
        s_d.result    = gp_out_i;
        s_d.result_oe = gp_oe_i;
      end
      default: begin
        s_d.mode      = MODE_NORMAL;
        s_d.pin_out   = '0;
        s_d.pin_oe    = '0;
        s_d.lad_out   = 1'b0;
        s_d.lad_oe    = 1'b0;
        s_d.result    = `RESULT_RST;
        s_d.result_oe = `RESULT_OE_RST;
      end
    endcase
  end

  // power-on reset of the main supply always returns to normal mode
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      s_q.host_prev <= `HOST_PREV_RST;
      s_q.mode      <= MODE_NORMAL;
      s_q.result    <= `RESULT_RST;
      s_q.result_oe <= `RESULT_OE_RST;
      s_q.pin_out   <= '0;
      s_q.pin_oe    <= '0;
      s_q.lad_out   <= `LAD_OUT_RST;
      s_q.lad_oe    <= `LAD_OE_RST;
    end else begin
      s_q <= s_d;
    end
  end

  // outputs straight from the state flops
  assign pin_out_o             = s_q.pin_out;
  assign pin_oe_o              = s_q.pin_oe;
  assign lad0_out_o            = s_q.lad_out;
  assign lad0_oe_o             = s_q.lad_oe;
  assign chain_result_pin_o    = s_q.result;
  assign chain_result_pin_oe_o = s_q.result_oe;
  assign mode_o                = s_q.mode;

  // checks on the mode machine and the chain result
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rstn_i);

  property p_enter;
    host_rise && select_chain |=> s_q.mode == MODE_CHAIN;
  endproperty
  a_enter: assert property (p_enter) else $error("chain mode not entered");

  property p_exit;
    host_rise && !select_chain |=> s_q.mode == MODE_NORMAL;
  endproperty
  a_exit: assert property (p_exit) else $error("chain mode not left");

  property p_release;
    s_q.mode == MODE_CHAIN |-> pin_oe_o == '0 && !lad0_oe_o;
  endproperty
  a_release: assert property (p_release) else $error("pin driven in chain mode");

  property p_toggle;
    s_q.mode == MODE_CHAIN && s_d.mode == MODE_CHAIN
      && $countones(chain.taps ^ $past(chain.taps)) == 1
      ##1 s_d.mode == MODE_CHAIN
    |-> chain_result_pin_o != $past(chain_result_pin_o);
  endproperty
  a_toggle: assert property (p_toggle) else $error("single flip missed");

  property p_parity;
    s_q.mode == MODE_CHAIN
    |-> chain_result_pin_o == $past(^{pin_in_i, lad0_i, lframe_n_i});
  endproperty
  a_parity: assert property (p_parity) else $error("result not chain parity");

  property p_result_oe;
    s_q.mode == MODE_CHAIN |-> chain_result_pin_oe_o ##1 (s_q.mode == MODE_NORMAL
      || chain_result_pin_oe_o);
  endproperty
  a_result_oe: assert property (p_result_oe) else $error("result pin not driven");

  property p_selectors_plain;
    s_q.mode == MODE_CHAIN && !host_rise |=> s_q.mode == MODE_CHAIN;
  endproperty
  a_selectors_plain: assert property (p_selectors_plain) else $error("selector left mode");

  property p_por;
    $rose(rstn_i) |-> s_q.mode == MODE_NORMAL && !chain_result_pin_oe_o;
  endproperty
  a_por: assert property (p_por) else $error("reset left chain mode on");

  // skip the first edge after release: the result pin still shows its reset value there
  property p_isolated;
    s_q.mode == MODE_NORMAL && $past(rstn_i) |-> chain_result_pin_o == $past(gp_out_i)
      && chain_result_pin_oe_o == $past(gp_oe_i);
  endproperty
  a_isolated: assert property (p_isolated) else $error("chain leaks in normal mode");

  property p_entry_low;
    $past(host_rise && select_chain) && $past(chain.taps) == '0
    |-> !chain_result_pin_o;
  endproperty
  a_entry_low: assert property (p_entry_low) else $error("entry result not low");

  property p_hold;
    !host_rise |=> $stable(s_q.mode);
  endproperty
  a_hold: assert property (p_hold) else $error("mode moved without release");

  // main scenarios
  property p_cv_enter;
    s_q.mode == MODE_NORMAL ##1 s_q.mode == MODE_CHAIN;
  endproperty
  c_enter: cover property (p_cv_enter);

  property p_cv_exit;
    s_q.mode == MODE_CHAIN ##1 s_q.mode == MODE_NORMAL;
  endproperty
  c_exit: cover property (p_cv_exit);

  property p_cv_flip;
    s_q.mode == MODE_CHAIN && $changed(chain_result_pin_o);
  endproperty
  c_flip: cover property (p_cv_flip);
endmodule

// file: testbench/board_tester.sv
`timescale 1ns/10ps
// board tester: pulses host reset low while the bench holds the selector levels
module board_tester (
  input  wire logic clk_i,
  input  wire logic step_i,
  output logic      host_reset_n_o
);
  logic [1:0] cnt_q  = 2'h0;
  logic       host_q = 1'b1;

  // host reset idles high; one process owns its level
  assign host_reset_n_o = host_q;

  // two cycles low, then the rising step that the device decides on
  always @(posedge clk_i) begin
    if (step_i) begin
      cnt_q  <= 2'h2;
      host_q <= 1'b0;
    end else if (cnt_q != 2'h0) begin
      cnt_q  <= cnt_q - 2'h1;
      host_q <= (cnt_q == 2'h1);
    end
  end
endmodule

// file: testbench/board_parity_test_chain_test.sv
`timescale 1ns/10ps
module board_parity_test_chain_test;
  import chain_pkg::*;
  logic        clk_i = 1'b0;
  logic        rstn_i = 1'b0;
  logic        step = 1'b0;
  logic        gp = 1'b1;
  logic        host_n;
  logic [89:0] taps = '0;
  logic [87:0] f = '1;
  logic [87:0] fo = {22{4'h5}};
  logic [87:0] p_out, p_oe;
  logic        l_out, l_oe, res, res_oe;
  test_mode_t  mode;
  int          n_mismatch = 0;
  int          n_checks = 0;
  int          cyc = 0;

  // 200 MHz clock
  always #2.5 clk_i = ~clk_i;

  board_tester tst_u (.clk_i(clk_i), .step_i(step), .host_reset_n_o(host_n));

  board_parity_test_chain dut_u (
    .clk_i(clk_i), .rstn_i(rstn_i), .host_reset_n_i(host_n),
    .lframe_n_i(taps[0]), .lad0_i(taps[1]), .pin_in_i(taps[89:2]),
    .func_out_i(fo), .func_oe_i(f), .lad0_func_out_i(f[0]), .lad0_func_oe_i(f[1]),
    .gp_out_i(gp), .gp_oe_i(~gp), .pin_out_o(p_out), .pin_oe_o(p_oe),
    .lad0_out_o(l_out), .lad0_oe_o(l_oe), .chain_result_pin_o(res),
    .chain_result_pin_oe_o(res_oe), .mode_o(mode)
  );

  task automatic chk(input logic [89:0] s, input logic [89:0] e);
    n_checks++;
    if (s !== e) begin
      n_mismatch++;
      $display("Error at %0t: seen %h expected %h", $time, s, e);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask

  task automatic set_taps(input logic [89:0] v);
    @(posedge clk_i);
    taps <= v;
    tick(2);
  endtask

  // one host reset pulse with the selectors as they stand
  task automatic pulse;
    @(posedge clk_i);
    step <= 1'b1;
    @(posedge clk_i);
    step <= 1'b0;
    tick(6);
  endtask

  task automatic t_enter;
    set_taps('0);
    pulse();
    chk(90'(mode), 90'(MODE_CHAIN));
    chk(90'(res), 90'h0);
    chk(90'(res_oe), 90'h1);
    chk(90'({p_oe, l_oe}), 90'h0);
    chk(90'({p_out, l_out}), 90'h0);
    $display("test enter done");
  endtask

  // raise taps one by one; each step flips the result
  task automatic t_walk;
    for (int i = 0; i < 90; i++) begin
      set_taps(taps | (90'h1 << i));
      chk(90'(res), 90'((i + 1) % 2));
    end
    chk(90'(mode), 90'(MODE_CHAIN));
    $display("test walk done");
  endtask

  // leave through each selector, then toggles must not reach the result
  task automatic t_exit;
    for (int k = 1; k < 3; k++) begin
      t_enter();
      set_taps(90'(k));
      pulse();
      chk(90'(mode), 90'(MODE_NORMAL));
      set_taps(90'(k) | 90'h20);
      chk(90'({res, res_oe}), 90'({gp, ~gp}));
      chk(90'(p_oe), 90'(f));
      chk(90'({p_out, l_out, l_oe}), 90'({fo, 2'b11}));
    end
    $display("test exit done");
  endtask

  task automatic t_por;
    t_enter();
    @(posedge clk_i);
    rstn_i <= 1'b0;
    tick(2);
    @(posedge clk_i);
    rstn_i <= 1'b1;
    tick(2);
    chk(90'(mode), 90'(MODE_NORMAL));
    chk(90'({res, res_oe}), 90'({gp, ~gp}));
    $display("test por done");
  endtask

  task automatic give_verdict;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // cut a hang short
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 3000) begin
      n_mismatch++;
      give_verdict();
    end
  end

  // main sequence
  initial begin
    repeat (12) @(posedge clk_i);
    rstn_i <= 1'b1;
    tick(2);
    t_enter();
    t_walk();
    t_exit();
    t_por();
    give_verdict();
  end
endmodule
